// File: design/udcm_cell_mux.sv
// Dual-port UTOPIA cell multiplexer: primary ATM side, secondary PHY side
`timescale 1ns/1ps
`include "udcm_cfg.svh"

module udcm_cell_mux #(
    parameter int CELL_OCTETS = `UDCM_CELL_OCTETS,
    parameter int CHANNEL_LIMIT = `UDCM_CHANNEL_LIMIT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [1:0] tx_clock_select,
    input wire logic primary_tx_link_clock_in,
    output logic primary_tx_link_clock_out,
    output logic primary_tx_link_clock_oe,
    output logic [7:0] primary_tx_octet_bus,
    output logic primary_tx_cell_start,
    output logic primary_tx_enable_out_n,
    output logic primary_tx_parity_out,
    input wire logic primary_tx_cell_avail_in,
    input wire logic primary_rx_link_clock,
    input wire logic [7:0] primary_rx_octet_bus,
    input wire logic primary_rx_cell_start,
    input wire logic primary_rx_cell_avail_in,
    input wire logic primary_rx_enable_in_n,
    input wire logic secondary_tx_link_clock,
    input wire logic [7:0] secondary_tx_octet_bus,
    input wire logic secondary_tx_cell_start,
    input wire logic secondary_tx_enable_in_n,
    output logic secondary_tx_cell_avail_out,
    input wire logic internal_cell_ready,
    input wire logic [7:0] internal_octet,
    output logic internal_octet_take,
    output logic [7:0] rx_octet,
    output logic rx_cell_start,
    output logic rx_octet_valid,
    output logic rx_cell_avail,
    input wire logic [`UDCM_CHANNEL_WIDTH-1:0] tx_channel_count,
    input wire logic [`UDCM_CHANNEL_WIDTH-1:0] rx_channel_count,
    output logic channel_limit_error
);
    import udcm_pkg::*;

    localparam logic [`UDCM_COUNT_WIDTH-1:0] LAST_INDEX = (`UDCM_COUNT_WIDTH)'(CELL_OCTETS - 1);
    localparam logic [`UDCM_COUNT_WIDTH-1:0] FULL_COUNT = (`UDCM_COUNT_WIDTH)'(CELL_OCTETS);
    localparam logic [`UDCM_CHANNEL_WIDTH-1:0] LIMIT = (`UDCM_CHANNEL_WIDTH)'(CHANNEL_LIMIT);

    // Clock generation state
    logic gen_clock; // Internally made transmit link clock
    logic div_phase; // Half-rate phase for divide by 4
    logic chosen_prev; // Last level of the selected clock
    logic next_gen_clock;
    logic next_div_phase;
    logic chosen_level; // Selected transmit clock level
    logic tx_tick; // Falling edge of selected clock

    // Link clock history for edge detection
    logic stx_prev;
    logic prx_prev;
    logic stx_rise;
    logic prx_rise;

    // Transmit multiplexer state
    udcm_tx_state_type tx_state;
    udcm_tx_state_type next_tx_state;
    logic [`UDCM_COUNT_WIDTH-1:0] tx_count; // Index of the next octet to send
    logic [`UDCM_COUNT_WIDTH-1:0] next_tx_count;
    logic last_secondary; // Fairness: last cell came from secondary
    logic next_last_secondary;
    logic [7:0] next_tx_octet;
    logic next_tx_start;
    logic next_tx_enable_n;
    logic next_take;
    logic clear_full; // Secondary cell fully forwarded

    // Secondary port capture state
    logic [`UDCM_COUNT_WIDTH-1:0] wr_count;
    logic [`UDCM_COUNT_WIDTH-1:0] next_wr_count;
    logic sec_full; // One whole cell held
    logic next_sec_full;
    logic mem_we;
    logic [`UDCM_COUNT_WIDTH-1:0] mem_waddr;
    logic [7:0] mem_rdata;

    // Receive capture next values
    logic [7:0] next_rx_octet;
    logic next_rx_start;
    logic next_rx_valid;
    logic next_rx_avail;

    // Edge detects; link inputs are synchronous to clock, so no synchroniser
    assign stx_rise = secondary_tx_link_clock & ~stx_prev;
    assign prx_rise = primary_rx_link_clock & ~prx_prev;
    // External source is read from the pin, the others from our own register
    assign chosen_level = (tx_clock_select == `UDCM_CLKSEL_EXTERNAL) ?
        primary_tx_link_clock_in : gen_clock;
    // Drive on falling edge so the PHY sees half a period of setup
    assign tx_tick = chosen_prev & ~chosen_level;

    // Transmit clock source and divider
    always_comb
    begin
        next_gen_clock = gen_clock;
        next_div_phase = ~div_phase;
        case (tx_clock_select)
            `UDCM_CLKSEL_SECONDARY:
                next_gen_clock = secondary_tx_link_clock;
            `UDCM_CLKSEL_DIV2:
                next_gen_clock = ~gen_clock;
            `UDCM_CLKSEL_DIV4:
                next_gen_clock = div_phase ? ~gen_clock : gen_clock;
            default:
                next_gen_clock = 1'b0; // External: our copy rests low
        endcase
    end

    // Clock registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gen_clock <= 1'b0;
            div_phase <= 1'b0;
            chosen_prev <= 1'b0;
            stx_prev <= 1'b0;
            prx_prev <= 1'b0;
            primary_tx_link_clock_out <= 1'b0;
            primary_tx_link_clock_oe <= 1'b0;
        end
        else
        begin
            gen_clock <= next_gen_clock;
            div_phase <= next_div_phase;
            chosen_prev <= chosen_level;
            stx_prev <= secondary_tx_link_clock;
            prx_prev <= primary_rx_link_clock;
            primary_tx_link_clock_out <= next_gen_clock;
            // Release the pin only for an external source
            primary_tx_link_clock_oe <= (tx_clock_select != `UDCM_CLKSEL_EXTERNAL);
        end
    end

    // Transmit multiplexer next state
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_count = tx_count;
        next_last_secondary = last_secondary;
        next_tx_octet = primary_tx_octet_bus;
        next_tx_start = primary_tx_cell_start;
        next_tx_enable_n = primary_tx_enable_out_n;
        next_take = 1'b0;
        clear_full = 1'b0;
        if (tx_tick)
        begin
            next_tx_start = 1'b0;
            case (tx_state)
                UDCM_TX_IDLE:
                begin
                    // Pick a source only between cells
                    next_tx_enable_n = 1'b1;
                    if (primary_tx_cell_avail_in && sec_full &&
                        (!internal_cell_ready || !last_secondary))
                    begin
                        next_tx_state = UDCM_TX_SECONDARY;
                        next_tx_octet = mem_rdata;
                        next_tx_start = 1'b1;
                        next_tx_enable_n = 1'b0;
                        next_tx_count = `UDCM_RESET_COUNT + 6'h01;
                        next_last_secondary = 1'b1;
                    end
                    else if (primary_tx_cell_avail_in && internal_cell_ready)
                    begin
                        next_tx_state = UDCM_TX_INTERNAL;
                        next_tx_octet = internal_octet;
                        next_tx_start = 1'b1;
                        next_tx_enable_n = 1'b0;
                        next_take = 1'b1;
                        next_tx_count = `UDCM_RESET_COUNT + 6'h01;
                        next_last_secondary = 1'b0;
                    end
                end
                UDCM_TX_INTERNAL, UDCM_TX_SECONDARY:
                begin
                    if (tx_count == FULL_COUNT)
                    begin
                        // Whole cell sent; no bytes of two cells interleave
                        next_tx_state = UDCM_TX_IDLE;
                        next_tx_enable_n = 1'b1;
                        next_tx_count = `UDCM_RESET_COUNT;
                        clear_full = (tx_state == UDCM_TX_SECONDARY);
                    end
                    else
                    begin
                        // Mid-cell octet, sent regardless of cell-available
                        next_tx_octet = (tx_state == UDCM_TX_SECONDARY) ?
                            mem_rdata : internal_octet;
                        next_take = (tx_state == UDCM_TX_INTERNAL);
                        next_tx_count = tx_count + 6'h01;
                    end
                end
                default:
                begin
                    next_tx_state = UDCM_TX_IDLE;
                    next_tx_enable_n = 1'b1;
                    next_tx_count = `UDCM_RESET_COUNT;
                end
            endcase
        end
    end

    // Transmit multiplexer registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            tx_state <= UDCM_TX_IDLE;
            tx_count <= `UDCM_RESET_COUNT;
            last_secondary <= 1'b0;
            primary_tx_octet_bus <= `UDCM_RESET_OCTET;
            primary_tx_cell_start <= 1'b0;
            primary_tx_enable_out_n <= 1'b1;
            primary_tx_parity_out <= 1'b1;
            internal_octet_take <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_count <= next_tx_count;
            last_secondary <= next_last_secondary;
            primary_tx_octet_bus <= next_tx_octet;
            primary_tx_cell_start <= next_tx_start;
            primary_tx_enable_out_n <= next_tx_enable_n;
            primary_tx_parity_out <= ~^next_tx_octet; // Odd parity
            internal_octet_take <= next_take;
        end
    end

    // Secondary port capture, acting as a PHY toward the attached SAR
    always_comb
    begin
        next_wr_count = wr_count;
        next_sec_full = sec_full & ~clear_full;
        mem_we = 1'b0;
        mem_waddr = wr_count;
        if (stx_rise && !secondary_tx_enable_in_n && !sec_full)
        begin
            if (secondary_tx_cell_start)
            begin
                // Start of cell realigns the store
                mem_we = 1'b1;
                mem_waddr = `UDCM_RESET_COUNT;
                next_wr_count = `UDCM_RESET_COUNT + 6'h01;
            end
            else if (wr_count != `UDCM_RESET_COUNT)
            begin
                mem_we = 1'b1;
                next_wr_count = wr_count + 6'h01;
                if (wr_count == LAST_INDEX)
                begin
                    next_sec_full = 1'b1;
                    next_wr_count = `UDCM_RESET_COUNT;
                end
            end
        end
    end

    // Secondary port registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_count <= `UDCM_RESET_COUNT;
            sec_full <= 1'b0;
            secondary_tx_cell_avail_out <= 1'b0;
        end
        else
        begin
            wr_count <= next_wr_count;
            sec_full <= next_sec_full;
            // Room for a cell while the store holds no whole cell
            secondary_tx_cell_avail_out <= ~next_sec_full;
        end
    end

    // Primary receive capture
    always_comb
    begin
        next_rx_octet = rx_octet;
        next_rx_start = rx_cell_start;
        next_rx_valid = 1'b0;
        next_rx_avail = rx_cell_avail;
        if (prx_rise)
        begin
            next_rx_avail = primary_rx_cell_avail_in;
            // Enable is observed, never driven; tied low takes every octet
            if (!primary_rx_enable_in_n)
            begin
                next_rx_octet = primary_rx_octet_bus;
                next_rx_start = primary_rx_cell_start;
                next_rx_valid = 1'b1;
            end
        end
    end

    // Receive registers and channel capacity check
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rx_octet <= `UDCM_RESET_OCTET;
            rx_cell_start <= 1'b0;
            rx_octet_valid <= 1'b0;
            rx_cell_avail <= 1'b0;
            channel_limit_error <= 1'b0;
        end
        else
        begin
            rx_octet <= next_rx_octet;
            rx_cell_start <= next_rx_start;
            rx_octet_valid <= next_rx_valid;
            rx_cell_avail <= next_rx_avail;
            channel_limit_error <= (tx_channel_count > LIMIT) ||
                (rx_channel_count > LIMIT);
        end
    end

    // Secondary cell store; read address tracks the next octet to send
    udcm_cell_memory #(
        .DEPTH(CELL_OCTETS),
        .ADDR_WIDTH(`UDCM_COUNT_WIDTH),
        .DATA_WIDTH(8)
    ) u_store (
        .clock(clock),
        .write_enable(mem_we),
        .write_address(mem_waddr),
        .write_data(secondary_tx_octet_bus),
        .read_address(tx_count),
        .read_data(mem_rdata)
    );

endmodule

// File: design/udcm_cfg.svh
// Constants of the dual-port UTOPIA cell multiplexer
`ifndef UDCM_CFG_SVH
`define UDCM_CFG_SVH

// Octets in one ATM cell on the 8-bit UTOPIA bus
`define UDCM_CELL_OCTETS 53
// Width of an octet counter
`define UDCM_COUNT_WIDTH 6
// Largest channel count per direction
`define UDCM_CHANNEL_LIMIT 1024
// Width of a channel count
`define UDCM_CHANNEL_WIDTH 11

// Primary transmit clock source codes
`define UDCM_CLKSEL_SECONDARY 2'h0
`define UDCM_CLKSEL_DIV2 2'h1
`define UDCM_CLKSEL_DIV4 2'h2
`define UDCM_CLKSEL_EXTERNAL 2'h3

// Reset values
`define UDCM_RESET_OCTET 8'h00
`define UDCM_RESET_COUNT 6'h00

`endif

// File: design/udcm_pkg.sv
// Types shared by the cell multiplexer files
package udcm_pkg;

    // Transmit multiplexer states, one-hot
    typedef enum logic [2:0]
    {
        UDCM_TX_IDLE = 3'h1,
        UDCM_TX_INTERNAL = 3'h2,
        UDCM_TX_SECONDARY = 3'h4
    } udcm_tx_state_type;

endpackage

// File: design/udcm_cell_memory.sv
// One-cell store for octets arriving on the secondary port
`timescale 1ns/1ps

module udcm_cell_memory #(
    parameter int DEPTH = 53,
    parameter int ADDR_WIDTH = 6,
    parameter int DATA_WIDTH = 8
) (
    input wire logic clock,
    input wire logic write_enable,
    input wire logic [ADDR_WIDTH-1:0] write_address,
    input wire logic [DATA_WIDTH-1:0] write_data,
    input wire logic [ADDR_WIDTH-1:0] read_address,
    output logic [DATA_WIDTH-1:0] read_data
);

    // Storage array, no reset needed for data
    logic [DATA_WIDTH-1:0] store [DEPTH];

    // Write port
    always_ff @(posedge clock)
    begin
        if (write_enable)
        begin
            store[write_address] <= write_data;
        end
    end

    // Registered read port, one cycle latency
    always_ff @(posedge clock)
    begin
        read_data <= store[read_address];
    end

endmodule

// File: sim/udcm_cell_mux_assertions.sv
// Port-level checker for the dual-port cell multiplexer
`timescale 1ns/1ps
`include "udcm_cfg.svh"
module udcm_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic [1:0] tx_clock_select,
    input wire logic primary_tx_link_clock_oe,
    input wire logic [7:0] primary_tx_octet_bus,
    input wire logic primary_tx_cell_start,
    input wire logic primary_tx_enable_out_n,
    input wire logic primary_tx_parity_out,
    input wire logic primary_rx_link_clock,
    input wire logic primary_rx_enable_in_n,
    input wire logic secondary_tx_link_clock,
    input wire logic secondary_tx_cell_avail_out,
    input wire logic [7:0] internal_octet,
    input wire logic internal_octet_take,
    input wire logic rx_octet_valid,
    input wire logic [`UDCM_CHANNEL_WIDTH-1:0] tx_channel_count,
    input wire logic [`UDCM_CHANNEL_WIDTH-1:0] rx_channel_count,
    input wire logic channel_limit_error
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // Odd parity always matches the driven octet
    parity_odd_a: assert property (primary_tx_parity_out == ~^primary_tx_octet_bus)
        else $error("transmit parity not odd");
    // Start of cell only while a cell is enabled
    start_in_cell_a: assert property (primary_tx_cell_start |-> !primary_tx_enable_out_n)
        else $error("cell start outside enable");
    // First enabled octet of a cell carries the start flag
    cell_opens_a: assert property ($fell(primary_tx_enable_out_n) |-> primary_tx_cell_start)
        else $error("cell opened without start");
    // Pin driven only for internal clock sources
    pin_drive_a: assert property ((tx_clock_select != 2'h3)[*3] |-> primary_tx_link_clock_oe)
        else $error("clock pin not driven");
    pin_release_a: assert property ((tx_clock_select == 2'h3)[*2] |-> !primary_tx_link_clock_oe)
        else $error("clock pin driven for external source");
    // Internal octet handed over is the one on the bus
    take_octet_a: assert property (internal_octet_take |->
        !primary_tx_enable_out_n && primary_tx_octet_bus == $past(internal_octet))
        else $error("taken octet not on bus");
    // Received octet needs the enable low at the clock rise
    rx_gate_a: assert property (rx_octet_valid |->
        $past(!primary_rx_enable_in_n) && $past(primary_rx_link_clock))
        else $error("octet accepted without enable");
    rx_pulse_a: assert property (rx_octet_valid |=> !rx_octet_valid)
        else $error("valid longer than one cycle");
    // Store fills only on a secondary clock rise
    store_full_a: assert property ($fell(secondary_tx_cell_avail_out) |->
        $past(secondary_tx_link_clock) || $past(secondary_tx_link_clock, 2))
        else $error("store full without clock");
    channel_limit_a: assert property (1'b1 |=> channel_limit_error ==
        $past(tx_channel_count > 11'h400 || rx_channel_count > 11'h400))
        else $error("channel limit flag wrong");
    cover property (internal_octet_take);
    cover property ($fell(secondary_tx_cell_avail_out));
    cover property (rx_octet_valid);
endmodule

// File: sim/udcm_phy_model.sv
// PHY partner: captures transmit octets, sends receive octets
`timescale 1ns/1ps
module udcm_phy_model (
    input wire logic clock,
    input wire logic link_clock,
    input wire logic [7:0] tx_octet,
    input wire logic tx_start,
    input wire logic tx_enable_n,
    input wire logic tx_parity,
    output logic [7:0] rx_octet,
    output logic rx_start,
    output logic rx_link_clock
);
    logic [9:0] got_q[$]; // Parity, start, octet
    logic last_link;
    initial
    begin
        rx_octet = 8'h5a;
        rx_start = 1'b0;
        rx_link_clock = 1'b0;
        last_link = 1'b0;
    end
    // Sample mid-cycle on the link clock rise, as a PHY would
    always @(negedge clock)
    begin
        if (link_clock && !last_link && tx_enable_n === 1'b0)
            got_q.push_back({tx_parity, tx_start, tx_octet});
        last_link = link_clock;
    end
    // One octet per receive clock period; lines scrambled once the rise is seen
    task automatic rx_send(input logic [7:0] d, input logic s);
        rx_octet = d;
        rx_start = s;
        repeat (2) @(posedge clock);
        #1 rx_link_clock = 1'b1;
        @(posedge clock);
        // Scrambling here catches a late sample, and never meets the next octet
        #1 rx_octet = ~d;
        rx_start = ~s;
        @(posedge clock);
        #1 rx_link_clock = 1'b0;
    endtask
endmodule

// File: sim/tb.sv
// Self-checking bench of the dual-port cell multiplexer
`timescale 1ns/1ps
module tb;
    import udcm_pkg::*;
    logic clock, srst, txclk_in, tx_avail, rx_avail_in, rx_en_n, sclk, s_start, s_en_n;
    logic [1:0] sel;
    logic [7:0] s_data, int_base, d;
    logic [10:0] tx_cnt, rx_cnt;
    logic clk_out, clk_oe, p_start, p_en_n, p_par, take, rx_start_o, rx_valid, rx_cav, lim_err;
    logic s_cav;
    logic [7:0] p_octet, rx_octet_o, prx_octet;
    logic prx_start, prx_clk, last_out;
    logic [9:0] exp_q[$];
    logic [8:0] rx_exp[$], rx_got[$];
    int err_count, samples_checked, seed, int_idx, int_limit, tog;
    wire logic [7:0] int_octet = int_base + int_idx[7:0]; // Internal source model
    wire logic int_ready = int_idx < int_limit;
    udcm_cell_mux dut (.clock(clock), .srst(srst), .tx_clock_select(sel),
        .primary_tx_link_clock_in(txclk_in), .primary_tx_link_clock_out(clk_out),
        .primary_tx_link_clock_oe(clk_oe), .primary_tx_octet_bus(p_octet),
        .primary_tx_cell_start(p_start), .primary_tx_enable_out_n(p_en_n),
        .primary_tx_parity_out(p_par), .primary_tx_cell_avail_in(tx_avail),
        .primary_rx_link_clock(prx_clk), .primary_rx_octet_bus(prx_octet),
        .primary_rx_cell_start(prx_start), .primary_rx_cell_avail_in(rx_avail_in),
        .primary_rx_enable_in_n(rx_en_n), .secondary_tx_link_clock(sclk),
        .secondary_tx_octet_bus(s_data), .secondary_tx_cell_start(s_start),
        .secondary_tx_enable_in_n(s_en_n), .secondary_tx_cell_avail_out(s_cav),
        .internal_cell_ready(int_ready), .internal_octet(int_octet), .internal_octet_take(take),
        .rx_octet(rx_octet_o), .rx_cell_start(rx_start_o), .rx_octet_valid(rx_valid),
        .rx_cell_avail(rx_cav), .tx_channel_count(tx_cnt), .rx_channel_count(rx_cnt),
        .channel_limit_error(lim_err));
    udcm_phy_model phy (.clock(clock), .link_clock(clk_out), .tx_octet(p_octet),
        .tx_start(p_start), .tx_enable_n(p_en_n), .tx_parity(p_par), .rx_octet(prx_octet),
        .rx_start(prx_start), .rx_link_clock(prx_clk));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Internal source advances on each take pulse
    always @(posedge clock)
        if (take === 1'b1) #1 int_idx++;
    // Receive side monitor
    always @(negedge clock)
        if (rx_valid === 1'b1) rx_got.push_back({rx_start_o, rx_octet_o});
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) err_count++;
    endtask
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Expected cell of 53 octets from a start value or the secondary store
    task automatic push_cell(input logic [7:0] b, input logic [7:0] q[53], input bit sec);
        logic [7:0] v;
        for (int i = 0; i < 53; i++)
        begin
            v = sec ? q[i] : b + 8'(i);
            exp_q.push_back({~^v, i == 0, v});
        end
    endtask
    // Compare captured octets once the partner holds them all
    task automatic drain();
        for (int n = 0; n < 4000 && phy.got_q.size() < exp_q.size(); n++) @(posedge clock);
        // Step off the edge so the next stimulus never races the design
        #1;
        check(10'(phy.got_q.size()), 10'(exp_q.size()));
        while (exp_q.size() > 0 && phy.got_q.size() > 0)
            check(phy.got_q.pop_front(), exp_q.pop_front());
    endtask
    initial
    begin
        logic [7:0] sq[53];
        logic [7:0] none[53];
        seed = 48;
        {srst, txclk_in, tx_avail, rx_avail_in, rx_en_n, sclk, s_start, s_en_n} = 8'h81;
        {sel, s_data, tx_cnt, rx_cnt, int_idx, int_limit} = '0;
        none = '{default: 8'h00};
        int_base = 8'($random(seed));
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        check({p_en_n, p_par, s_cav, take, rx_valid, clk_oe}, 10'h30);
        repeat (2) @(posedge clock);
        check(s_cav, 1'b1);
        // Clock source toggle counts over 16 cycles
        for (int s = 0; s < 4; s++)
        begin
            sel = 2'(s);
            tog = 0;
            for (int c = 0; c < 22; c++)
            begin
                @(posedge clock);
                #1 sclk = c[1];
                txclk_in = c[0];
                if (c > 5 && clk_out !== last_out) tog++;
                last_out = clk_out;
            end
            check({clk_oe, 9'(tog)}, {s != 3, 9'(s == 1 ? 16 : s == 3 ? 0 : 8)});
        end
        sel = 2'h1;
        // Internal cell alone
        tx_avail = 1'b1;
        int_limit = 53;
        push_cell(int_base, none, 0);
        drain();
        // Secondary cell loaded while the PHY refuses
        tx_avail = 1'b0;
        s_en_n = 1'b0;
        for (int i = 0; i < 53; i++)
        begin
            sq[i] = 8'($random(seed));
            s_data = sq[i];
            s_start = i == 0;
            repeat (2) @(posedge clock);
            #1 sclk = 1'b1;
            repeat (2) @(posedge clock);
            #1 sclk = 1'b0;
        end
        s_en_n = 1'b1;
        int_limit = 106;
        repeat (100) @(posedge clock);
        check(s_cav, 1'b0);
        check(10'(phy.got_q.size()), 10'h0);
        // Both ready after an internal cell: secondary goes first
        push_cell(8'h0, sq, 1);
        push_cell(int_base + 8'd53, none, 0);
        #1 tx_avail = 1'b1;
        drain();
        check(s_cav, 1'b1);
        // Receive with the enable low, then refused with it high
        rx_avail_in = 1'b1;
        rx_en_n = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($random(seed));
            if (i == 4) rx_en_n = 1'b1;
            if (i < 4) rx_exp.push_back({i == 0, d});
            phy.rx_send(d, i == 0);
        end
        repeat (4) @(posedge clock);
        check(10'(rx_got.size()), 10'd4);
        check(rx_cav, 1'b1);
        while (rx_got.size() > 0 && rx_exp.size() > 0)
            check(rx_got.pop_front(), rx_exp.pop_front());
        // Internal cell with the clock divided by 4
        #1 sel = 2'h2;
        int_limit = 159;
        push_cell(int_base + 8'd106, none, 0);
        drain();
        // Channel count limit on each side
        for (int k = 0; k < 4; k++)
        begin
            #1 tx_cnt = (k == 1) ? 11'h401 : (k == 3) ? 11'h400 : 11'h0;
            rx_cnt = (k == 2) ? 11'h401 : (k == 3) ? 11'h400 : 11'h0;
            repeat (2) @(posedge clock);
            check(lim_err, k == 1 || k == 2);
        end
        conclude();
    end
    // Cut a hang short
    initial
    begin
        #(40 * 40000);
        err_count++;
        conclude();
    end
endmodule
bind udcm_cell_mux udcm_checker chk (.clock(clock), .srst(srst),
    .tx_clock_select(tx_clock_select), .primary_tx_link_clock_oe(primary_tx_link_clock_oe),
    .primary_tx_octet_bus(primary_tx_octet_bus), .primary_tx_cell_start(primary_tx_cell_start),
    .primary_tx_enable_out_n(primary_tx_enable_out_n),
    .primary_tx_parity_out(primary_tx_parity_out), .primary_rx_link_clock(primary_rx_link_clock),
    .primary_rx_enable_in_n(primary_rx_enable_in_n),
    .secondary_tx_link_clock(secondary_tx_link_clock),
    .secondary_tx_cell_avail_out(secondary_tx_cell_avail_out), .internal_octet(internal_octet),
    .internal_octet_take(internal_octet_take), .rx_octet_valid(rx_octet_valid),
    .tx_channel_count(tx_channel_count), .rx_channel_count(rx_channel_count),
    .channel_limit_error(channel_limit_error));
